// file: eq_coeff_pkg.sv
`default_nettype none
package eq_coeff_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 24;
  localparam int SAMPLE_W = 12;
  localparam int CENTRE_W = 18;
  localparam int SIDE_W = 12;
  localparam int NUM_TAPS = 9;
  localparam int NUM_REGS = 4;
  localparam int NUM_OTHER = 5;
  localparam int ACC_W = SAMPLE_W + CENTRE_W + 4;
  // Tap positions, counted from zero
  localparam int CENTRE_TAP = 4;
  localparam int TAP6_IDX = 5;
  localparam int TAP7_IDX = 6;
  localparam int TAP8_IDX = 7;
  localparam int TAP9_IDX = 8;
  localparam int OTHER_TAP9 = 4;
  // Register offsets
  localparam logic [ADDR_W-1:0] OFS_CENTRE = 12'h420;
  localparam logic [ADDR_W-1:0] OFS_TAP6 = 12'h423;
  localparam logic [ADDR_W-1:0] OFS_TAP7 = 12'h425;
  localparam logic [ADDR_W-1:0] OFS_TAP8 = 12'h427;
  localparam logic [ADDR_W-1:0] REG_OFFSET [NUM_REGS] = '{OFS_CENTRE, OFS_TAP6, OFS_TAP7, OFS_TAP8};
  // Writable bits, reserved bits included
  localparam logic [DATA_W-1:0] MASK_CENTRE = 24'hffffff;
  localparam logic [DATA_W-1:0] MASK_SIDE = 24'h00ffff;
  localparam logic [DATA_W-1:0] REG_MASK [NUM_REGS] = '{MASK_CENTRE, MASK_SIDE, MASK_SIDE, MASK_SIDE};
  // Field top bit that reads back as zero
  localparam logic [DATA_W-1:0] MSB_CENTRE = 24'h020000;
  localparam logic [DATA_W-1:0] MSB_SIDE = 24'h000800;
  localparam logic [DATA_W-1:0] REG_MSB [NUM_REGS] = '{MSB_CENTRE, MSB_SIDE, MSB_SIDE, MSB_SIDE};
  localparam logic [DATA_W-1:0] RESET_VAL = 24'h000000;
  localparam int CENTRE_RSVD_LO = 18;
  localparam int CENTRE_RSVD_HI = 23;
  localparam int SIDE_RSVD_LO = 12;
  localparam int SIDE_RSVD_HI = 15;
endpackage
`default_nettype wire

// file: eq_coeff_if.sv
`timescale 1ns/100ps
`default_nettype none
interface eq_coeff_if;
  logic signed [eq_coeff_pkg::CENTRE_W-1:0] tap [eq_coeff_pkg::NUM_TAPS];
  logic signed [eq_coeff_pkg::SAMPLE_W-1:0] sample;
  modport source (output tap, output sample);
  modport sink (input tap, input sample);
endinterface
`default_nettype wire

// file: eq_fir_core.sv
`timescale 1ns/100ps
`default_nettype none
module eq_fir_core
(
  input wire logic MCLK,
  input wire logic RESET_N,
  eq_coeff_if.sink cif,
  output logic signed [eq_coeff_pkg::ACC_W-1:0] result
);
  localparam int PROD_W = eq_coeff_pkg::SAMPLE_W + eq_coeff_pkg::CENTRE_W;
  localparam int RUN_W = 4;

  logic signed [eq_coeff_pkg::SAMPLE_W-1:0] dly [eq_coeff_pkg::NUM_TAPS];
  logic signed [PROD_W-1:0] prod [eq_coeff_pkg::NUM_TAPS];
  logic signed [eq_coeff_pkg::ACC_W-1:0] next_result;

  // ****************************************
  // Delay line and products
  // ****************************************
  genvar i;
  generate
    for (i = 0; i < eq_coeff_pkg::NUM_TAPS; i++)
    begin : g_tap
      always_ff @(posedge MCLK or negedge RESET_N)
      begin
        if (!RESET_N)
          dly[i] <= '0;
        else if (i == 0)
          dly[i] <= cif.sample;
        else
          dly[i] <= dly[(i == 0) ? 0 : i-1];
      end
      assign prod[i] = dly[i] * cif.tap[i]; // see RULE11
    end
  endgenerate

  always_comb
  begin
    next_result = '0;
    for (int k = 0; k < eq_coeff_pkg::NUM_TAPS; k++)
      next_result = next_result + eq_coeff_pkg::ACC_W'(prod[k]); // see RULE11
  end

  always_ff @(posedge MCLK or negedge RESET_N)
  begin
    if (!RESET_N)
      result <= '0;
    else
      result <= next_result;
  end

  // ****************************************
  // Checks
  // ****************************************
  logic [RUN_W-1:0] zero_run;
  always_ff @(posedge MCLK or negedge RESET_N)
  begin
    if (!RESET_N)
      zero_run <= '0;
    else if (cif.sample != '0)
      zero_run <= '0;
    else if (zero_run != '1)
      zero_run <= zero_run + 4'h1;
  end

  AST_FIR_FLUSH: assert property (@(posedge MCLK) disable iff (!RESET_N) // see RULE11
    (zero_run > RUN_W'(eq_coeff_pkg::NUM_TAPS)) |-> (result == '0))
    else $error("equalizer output not zero after zero input run");
endmodule
`default_nettype wire

// file: eq_coeff_regs.sv
`timescale 1ns/100ps
`default_nettype none
// Function
// RULE1 - Centre tap is 18-bit signed, bits 17:0
// RULE2 - Centre register feeds tap five in dual mode
// RULE3 - Single mode uses these taps on shared filter
// RULE4 - Centre bits 23:18 reserved, read-write, reset zero
// RULE5 - Tap six is 12-bit signed, bits 11:0
// RULE6 - Tap seven is 12-bit signed, bits 11:0
// RULE7 - Tap eight is 12-bit signed, bits 11:0
// RULE8 - Side tap bits 15:12 reserved, read-write, zero
// RULE9 - Readback returns field top bit as zero
// RULE10 - All coefficient fields reset to zero
// RULE11 - Filter sums nine coefficient-sample products
module eq_coeff_regs
(
  input wire logic MCLK,
  input wire logic RESET_N,
  input wire logic [eq_coeff_pkg::ADDR_W-1:0] ADDR,
  input wire logic [eq_coeff_pkg::DATA_W-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [eq_coeff_pkg::DATA_W-1:0] RDATA,
  input wire logic SINGLE_CHANNEL,
  input wire logic signed [eq_coeff_pkg::SAMPLE_W-1:0] CHA_SAMPLE,
  input wire logic signed [eq_coeff_pkg::SAMPLE_W-1:0] SHARED_SAMPLE,
  input wire logic [eq_coeff_pkg::NUM_OTHER*eq_coeff_pkg::SIDE_W-1:0] OTHER_COEFF,
  output logic signed [eq_coeff_pkg::ACC_W-1:0] EQ_OUT
);
  localparam int SW = eq_coeff_pkg::SIDE_W;
  localparam int CW = eq_coeff_pkg::CENTRE_W;
  localparam int PAD = CW - SW;

  eq_coeff_if cif ();

  logic [eq_coeff_pkg::DATA_W-1:0] coeff_reg [eq_coeff_pkg::NUM_REGS];
  logic [eq_coeff_pkg::NUM_REGS-1:0] hit;
  logic [eq_coeff_pkg::DATA_W-1:0] rd_term [eq_coeff_pkg::NUM_REGS];
  logic [eq_coeff_pkg::DATA_W-1:0] read_mux;
  logic [eq_coeff_pkg::DATA_W-1:0] next_rdata;
  logic any_hit;

  // ****************************************
  // Register storage
  // ****************************************
  genvar r;
  generate
    for (r = 0; r < eq_coeff_pkg::NUM_REGS; r++)
    begin : g_reg
      assign hit[r] = (ADDR == eq_coeff_pkg::REG_OFFSET[r]);
      // Reserved bits are stored too; only the field reaches the filter
      always_ff @(posedge MCLK or negedge RESET_N)
      begin
        if (!RESET_N)
          coeff_reg[r] <= eq_coeff_pkg::RESET_VAL; // see RULE10
        else if (WR && hit[r])
          coeff_reg[r] <= WDATA & eq_coeff_pkg::REG_MASK[r]; // see RULE4 see RULE8
      end
      // Field top bit always reads back as zero
      assign rd_term[r] = hit[r] ? (coeff_reg[r] & ~eq_coeff_pkg::REG_MSB[r]) : '0; // see RULE9
    end
  endgenerate

  // ****************************************
  // Read path
  // ****************************************
  assign any_hit = |hit;

  always_comb
  begin
    read_mux = '0;
    for (int k = 0; k < eq_coeff_pkg::NUM_REGS; k++)
      read_mux = read_mux | rd_term[k];
  end

  assign next_rdata = RD ? read_mux : '0;

  always_ff @(posedge MCLK or negedge RESET_N)
  begin
    if (!RESET_N)
      RDATA <= '0;
    else
      RDATA <= next_rdata;
  end

  // ****************************************
  // Coefficient mapping
  // ****************************************
  wire logic [SW-1:0] other_tap [eq_coeff_pkg::NUM_OTHER];

  genvar t;
  generate
    for (t = 0; t < eq_coeff_pkg::NUM_OTHER; t++)
    begin : g_other
      assign other_tap[t] = OTHER_COEFF[t*SW +: SW];
    end
    for (t = 0; t < eq_coeff_pkg::CENTRE_TAP; t++)
    begin : g_low
      assign cif.tap[t] = {{PAD{other_tap[t][SW-1]}}, other_tap[t]};
    end
  endgenerate

  assign cif.tap[eq_coeff_pkg::CENTRE_TAP] = coeff_reg[0][CW-1:0]; // see RULE1 see RULE2
  assign cif.tap[eq_coeff_pkg::TAP6_IDX] = {{PAD{coeff_reg[1][SW-1]}}, coeff_reg[1][SW-1:0]}; // see RULE5
  assign cif.tap[eq_coeff_pkg::TAP7_IDX] = {{PAD{coeff_reg[2][SW-1]}}, coeff_reg[2][SW-1:0]}; // see RULE6
  assign cif.tap[eq_coeff_pkg::TAP8_IDX] = {{PAD{coeff_reg[3][SW-1]}}, coeff_reg[3][SW-1:0]}; // see RULE7
  assign cif.tap[eq_coeff_pkg::TAP9_IDX] =
    {{PAD{other_tap[eq_coeff_pkg::OTHER_TAP9][SW-1]}}, other_tap[eq_coeff_pkg::OTHER_TAP9]};

  // Single mode runs the shared stream through the same taps
  assign cif.sample = SINGLE_CHANNEL ? SHARED_SAMPLE : CHA_SAMPLE; // see RULE3

  // ****************************************
  // Filter datapath
  // ****************************************
  eq_fir_core u_fir
  (
    .MCLK(MCLK),
    .RESET_N(RESET_N),
    .cif(cif.sink),
    .result(EQ_OUT)
  );

  // ****************************************
  // Checks
  // ****************************************
  wire logic side_hit = hit[1] | hit[2] | hit[3];

  AST_CENTRE_HOLD: assert property (@(posedge MCLK) disable iff (!RESET_N) // see RULE1
    (WR && hit[0]) |=> (cif.tap[eq_coeff_pkg::CENTRE_TAP] == $past(WDATA[CW-1:0])))
    else $error("centre coefficient not stored from write");

  AST_CENTRE_DUAL: assert property (@(posedge MCLK) disable iff (!RESET_N) // see RULE2
    (WR && hit[0] && !SINGLE_CHANNEL) ##1 !SINGLE_CHANNEL [*2]
      |-> (cif.tap[eq_coeff_pkg::CENTRE_TAP] == $past(WDATA[CW-1:0], 2)) || $past(WR))
    else $error("centre coefficient not on tap five in dual mode");

  AST_SHARED_SEL: assert property (@(posedge MCLK) disable iff (!RESET_N) // see RULE3
    SINGLE_CHANNEL |-> (cif.sample == SHARED_SAMPLE))
    else $error("shared stream not selected in single mode");

  AST_CENTRE_RSVD: assert property (@(posedge MCLK) disable iff (!RESET_N) // see RULE4
    (WR && hit[0]) ##1 (RD && hit[0]) |=>
      (RDATA[eq_coeff_pkg::CENTRE_RSVD_HI:eq_coeff_pkg::CENTRE_RSVD_LO]
        == $past(WDATA[eq_coeff_pkg::CENTRE_RSVD_HI:eq_coeff_pkg::CENTRE_RSVD_LO], 2)))
    else $error("centre reserved bits not read back");

  AST_TAP6: assert property (@(posedge MCLK) disable iff (!RESET_N) // see RULE5
    (WR && hit[1]) |=> ($signed(cif.tap[eq_coeff_pkg::TAP6_IDX]) == $signed($past(WDATA[SW-1:0]))))
    else $error("tap six coefficient wrong");

  AST_TAP7: assert property (@(posedge MCLK) disable iff (!RESET_N) // see RULE6
    (WR && hit[2]) |=> ($signed(cif.tap[eq_coeff_pkg::TAP7_IDX]) == $signed($past(WDATA[SW-1:0]))))
    else $error("tap seven coefficient wrong");

  AST_TAP8: assert property (@(posedge MCLK) disable iff (!RESET_N) // see RULE7
    (WR && hit[3]) |=> ($signed(cif.tap[eq_coeff_pkg::TAP8_IDX]) == $signed($past(WDATA[SW-1:0]))))
    else $error("tap eight coefficient wrong");

  AST_SIDE_RSVD: assert property (@(posedge MCLK) disable iff (!RESET_N) // see RULE8
    (WR && side_hit) ##1 (RD && ADDR == $past(ADDR)) |=>
      (RDATA[eq_coeff_pkg::SIDE_RSVD_HI:eq_coeff_pkg::SIDE_RSVD_LO]
        == $past(WDATA[eq_coeff_pkg::SIDE_RSVD_HI:eq_coeff_pkg::SIDE_RSVD_LO], 2))
      && (RDATA[eq_coeff_pkg::DATA_W-1:eq_coeff_pkg::SIDE_RSVD_HI+1] == '0))
    else $error("side tap reserved bits not read back");

  AST_MSB_ZERO: assert property (@(posedge MCLK) disable iff (!RESET_N) // see RULE9
    RD |=> ((RDATA & ($past(hit[0]) ? eq_coeff_pkg::MSB_CENTRE : eq_coeff_pkg::MSB_SIDE)) == '0))
    else $error("coefficient top bit not read as zero");

  AST_RESET_ZERO: assert property (@(posedge MCLK) disable iff (!RESET_N) // see RULE10
    $rose(RESET_N) |-> (cif.tap[eq_coeff_pkg::CENTRE_TAP] == '0) && (cif.tap[eq_coeff_pkg::TAP6_IDX] == '0)
      && (cif.tap[eq_coeff_pkg::TAP7_IDX] == '0) && (cif.tap[eq_coeff_pkg::TAP8_IDX] == '0))
    else $error("coefficients not zero after reset");

  AST_UNMAPPED: assert property (@(posedge MCLK) disable iff (!RESET_N)
    (RD && !any_hit) |=> (RDATA == '0))
    else $error("unmapped read not zero");

  AST_IDLE_READ: assert property (@(posedge MCLK) disable iff (!RESET_N)
    !RD |=> (RDATA == '0))
    else $error("read data present without a read");
endmodule
`default_nettype wire

// file: test_fir_equalizer_coeff_regs_a4_a7.sv
`timescale 1ns/100ps
`default_nettype none
module test_fir_equalizer_coeff_regs_a4_a7;
  logic MCLK;
  logic RESET_N;
  logic [eq_coeff_pkg::ADDR_W-1:0] ADDR;
  logic [eq_coeff_pkg::DATA_W-1:0] WDATA;
  logic WR;
  logic RD;
  logic [eq_coeff_pkg::DATA_W-1:0] RDATA;
  logic SINGLE_CHANNEL;
  logic signed [eq_coeff_pkg::SAMPLE_W-1:0] CHA_SAMPLE;
  logic signed [eq_coeff_pkg::SAMPLE_W-1:0] SHARED_SAMPLE;
  logic [eq_coeff_pkg::NUM_OTHER*eq_coeff_pkg::SIDE_W-1:0] OTHER_COEFF;
  logic signed [eq_coeff_pkg::ACC_W-1:0] EQ_OUT;
  int bad_count;
  int check_count;
  // Taps one to nine as the filter must see them
  int coef [1:9] = '{1, 2, 3, 4, -131069, -2048, 2047, 5, -1};

  eq_coeff_regs i_dut
  (
    .MCLK(MCLK),
    .RESET_N(RESET_N),
    .ADDR(ADDR),
    .WDATA(WDATA),
    .WR(WR),
    .RD(RD),
    .RDATA(RDATA),
    .SINGLE_CHANNEL(SINGLE_CHANNEL),
    .CHA_SAMPLE(CHA_SAMPLE),
    .SHARED_SAMPLE(SHARED_SAMPLE),
    .OTHER_COEFF(OTHER_COEFF),
    .EQ_OUT(EQ_OUT)
  );

  // ****************************************
  // Bus tasks
  // ****************************************
  task automatic bus_write(input logic [eq_coeff_pkg::ADDR_W-1:0] a, input logic [eq_coeff_pkg::DATA_W-1:0] d);
    @(posedge MCLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge MCLK);
    WR <= 1'b0;
  endtask

  task automatic expect_reg(input logic [eq_coeff_pkg::ADDR_W-1:0] a, input logic [eq_coeff_pkg::DATA_W-1:0] exp);
    logic [eq_coeff_pkg::DATA_W-1:0] d;
    @(posedge MCLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge MCLK);
    RD <= 1'b0;
    #1;
    d = RDATA;
    check_count++;
    if (d !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t: read %h got %h want %h", $time, a, d, exp);
    end
    @(posedge MCLK);
    #1;
    check_count++;
    if (RDATA !== 24'h000000)
    begin
      bad_count++;
      $display("mismatch at %0t: read data held past one cycle", $time);
    end
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic test_reset_values();
    for (int i = 0; i < eq_coeff_pkg::NUM_REGS; i++)
    begin
      expect_reg(eq_coeff_pkg::REG_OFFSET[i], 24'h000000);
    end
  endtask

  task automatic test_readback();
    logic [eq_coeff_pkg::DATA_W-1:0] wr_val [4] = '{24'hffffff, 24'hffffff, 24'h5a5a5a, 24'h0007ff};
    logic [eq_coeff_pkg::DATA_W-1:0] rd_val [4] = '{24'hfdffff, 24'h00f7ff, 24'h00525a, 24'h0007ff};
    for (int i = 0; i < eq_coeff_pkg::NUM_REGS; i++)
    begin
      bus_write(eq_coeff_pkg::REG_OFFSET[i], wr_val[i]);
    end
    bus_write(12'h421, 24'hffffff);
    for (int i = 0; i < eq_coeff_pkg::NUM_REGS; i++)
    begin
      expect_reg(eq_coeff_pkg::REG_OFFSET[i], rd_val[i]);
    end
    expect_reg(12'h421, 24'h000000);
  endtask

  // Write then read with no gap, centre register then tap six
  task automatic test_back_to_back();
    @(posedge MCLK);
    ADDR <= eq_coeff_pkg::OFS_CENTRE;
    WDATA <= 24'hfe0001;
    WR <= 1'b1;
    @(posedge MCLK);
    WR <= 1'b0;
    RD <= 1'b1;
    @(posedge MCLK);
    RD <= 1'b0;
    ADDR <= eq_coeff_pkg::OFS_TAP6;
    WDATA <= 24'h00a923;
    WR <= 1'b1;
    #1;
    check_count++;
    if (RDATA !== 24'hfc0001)
    begin
      bad_count++;
      $display("mismatch at %0t: centre back-to-back read got %h", $time, RDATA);
    end
    @(posedge MCLK);
    WR <= 1'b0;
    RD <= 1'b1;
    @(posedge MCLK);
    RD <= 1'b0;
    #1;
    check_count++;
    if (RDATA !== 24'h00a123)
    begin
      bad_count++;
      $display("mismatch at %0t: tap six back-to-back read got %h", $time, RDATA);
    end
  endtask

  task automatic apply_reset();
    @(posedge MCLK);
    RESET_N <= 1'b0;
    repeat (2) @(posedge MCLK);
    RESET_N <= 1'b1;
  endtask

  // Impulse of three on the selected stream, junk on the other one
  task automatic test_filter(input logic single);
    logic signed [eq_coeff_pkg::ACC_W-1:0] exp;
    bus_write(eq_coeff_pkg::OFS_CENTRE, 24'hfe0003);
    bus_write(eq_coeff_pkg::OFS_TAP6, 24'h00f800);
    bus_write(eq_coeff_pkg::OFS_TAP7, 24'h0007ff);
    bus_write(eq_coeff_pkg::OFS_TAP8, 24'h000005);
    SINGLE_CHANNEL <= single;
    CHA_SAMPLE <= single ? 12'sh7ff : 12'sh000;
    SHARED_SAMPLE <= single ? 12'sh000 : 12'sh7ff;
    repeat (12) @(posedge MCLK);
    #1;
    check_count++;
    if (EQ_OUT !== '0)
    begin
      bad_count++;
      $display("mismatch at %0t: unselected stream reached the filter", $time);
    end
    @(posedge MCLK);
    if (single) SHARED_SAMPLE <= 12'sh003;
    else CHA_SAMPLE <= 12'sh003;
    @(posedge MCLK);
    if (single) SHARED_SAMPLE <= 12'sh000;
    else CHA_SAMPLE <= 12'sh000;
    for (int k = 1; k <= eq_coeff_pkg::NUM_TAPS; k++)
    begin
      @(posedge MCLK);
      #1;
      exp = 3 * coef[k];
      check_count++;
      if (EQ_OUT !== exp)
      begin
        bad_count++;
        $display("mismatch at %0t: tap %0d got %0d want %0d", $time, k, EQ_OUT, exp);
      end
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ****************************************
  // Clock, watchdog and main sequence
  // ****************************************
  initial
  begin
    MCLK = 1'b0;
    forever #5 MCLK = ~MCLK;
  end

  initial
  begin
    #100000;
    bad_count++;
    print_verdict();
  end

  initial
  begin
    RESET_N = 1'b0;
    ADDR = '0;
    WDATA = '0;
    WR = 1'b0;
    RD = 1'b0;
    SINGLE_CHANNEL = 1'b0;
    CHA_SAMPLE = '0;
    SHARED_SAMPLE = '0;
    OTHER_COEFF = {12'hfff, 12'h004, 12'h003, 12'h002, 12'h001};
    bad_count = 0;
    check_count = 0;
    repeat (5) @(posedge MCLK);
    RESET_N <= 1'b1;
    test_reset_values();
    test_readback();
    test_back_to_back();
    test_filter(1'b0);
    test_filter(1'b1);
    apply_reset();
    test_reset_values();
    print_verdict();
  end
endmodule
`default_nettype wire
